// >>> common/facr_pkg.sv
package facr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_AUX_ZERO  = 8'h48;
  localparam logic [7:0] ADDR_SEQ_NEXT  = 8'h49;
  localparam logic [7:0] ADDR_SEQ_COUNT = 8'h4A;
  localparam logic [7:0] ADDR_SEQ_CTRL  = 8'h4B;
  localparam logic [7:0] ADDR_SEQ_DATA  = 8'h4C;
  localparam logic [7:0] ADDR_AUX_ONE   = 8'h4F;
  localparam logic [7:0] ADDR_BUF_PORT  = 8'h70;
  localparam logic [7:0] ADDR_FMT_CTRL  = 8'h71;
  localparam logic [7:0] ADDR_LOCK_REL  = 8'h73;
  localparam logic [7:0] ADDR_ECC_STAT  = 8'h79;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int A0_AUTO_INC   = 0;
  localparam int A0_PWR_DOWN   = 1;
  localparam int A0_ECC_ERR    = 2;
  localparam int A0_TWO_IDX    = 3;
  localparam int A0_CLR_DMA    = 4;
  localparam int A0_DATA_BR    = 5;
  localparam int A0_TWO_IDX_EN = 6;
  localparam int A0_SPLIT_EN   = 7;
  localparam int A1_BUSY_CLR   = 3;
  localparam int A1_FILT_DIS   = 4;
  localparam int A1_ECC_PRESET = 5;
  localparam int A1_WAIT_LO    = 6;
  localparam int A1_WAIT_HI    = 7;
  localparam int CTL_DATA_XFER = 0;
  localparam int CTL_SPLIT     = 3;
  localparam int CTL_SET_RG    = 6;
  localparam int CNT_TIMER_ARM = 5;
  localparam int FMT_RESET_BIT = 5;
  localparam int BRANCH_W      = 5;
  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX0_RESET      = 8'h00;
  localparam logic [7:0] AUX0_WRITE_MASK = 8'hF3;
  localparam logic [7:0] AUX1_RESET      = 8'hC0;
  localparam logic [7:0] AUX1_WRITE_MASK = 8'hF8;
  localparam logic [7:0] SEQ_RESET       = 8'h00;
  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DET_DISARMED = 2'b00,
    DET_ARMED    = 2'b01,
    DET_ONE_EDGE = 2'b10
  } facr_det_e;
  typedef enum logic {
    WS_IDLE = 1'b0,
    WS_WAIT = 1'b1
  } facr_wait_e;
endpackage

// >>> common/facr_seq_if.sv
`timescale 1ns/1ps
interface facr_seq_if;
  logic [7:0] wordCount;
  logic [7:0] wordControl;
  logic       execPulse;
  logic       modeEn;
  logic       detected;
  logic       armed;
  modport owner (
    output wordCount,
    output wordControl,
    output execPulse,
    output modeEn,
    input  detected,
    input  armed
  );
  modport detector (
    input  wordCount,
    input  wordControl,
    input  execPulse,
    input  modeEn,
    output detected,
    output armed
  );
endinterface

// >>> logic/facr_two_index.sv
`timescale 1ns/1ps
module facr_two_index (
  input  wire logic     clk,
  input  wire logic     reset,
  facr_seq_if.detector  seq,
  input  wire logic     indexEdge,
  input  wire logic     bufTransfer
);
  facr_pkg::facr_det_e state_reg;
  facr_pkg::facr_det_e state_next;
  logic                det_reg;
  logic                det_next;
  logic                armCond;

  // ----------------------------------------------------------------
  // arming and detection
  // ----------------------------------------------------------------
  assign armCond = !seq.wordControl[facr_pkg::CTL_SET_RG]
                && !seq.wordControl[facr_pkg::CTL_DATA_XFER]
                && seq.wordCount[facr_pkg::CNT_TIMER_ARM];

  always_comb begin
    state_next = state_reg;
    det_next   = det_reg;
    if (!seq.modeEn) begin
      state_next = facr_pkg::DET_DISARMED;
      det_next   = 1'b0;
    end else if (seq.execPulse && armCond) begin
      state_next = facr_pkg::DET_ARMED;
      det_next   = 1'b0;
    end else begin
      unique case (state_reg)
        facr_pkg::DET_DISARMED: begin
        end
        facr_pkg::DET_ARMED: begin
          if (bufTransfer) begin
            state_next = facr_pkg::DET_DISARMED;
          end else if (indexEdge) begin
            state_next = facr_pkg::DET_ONE_EDGE;
          end
        end
        facr_pkg::DET_ONE_EDGE: begin
          if (bufTransfer) begin
            state_next = facr_pkg::DET_DISARMED;
          end else if (indexEdge) begin
            state_next = facr_pkg::DET_DISARMED;
            det_next   = 1'b1;
          end
        end
        default: begin
          state_next = facr_pkg::DET_DISARMED;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= facr_pkg::DET_DISARMED;
      det_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      det_reg   <= det_next;
    end
  end

  assign seq.detected = det_reg;
  assign seq.armed    = (state_reg != facr_pkg::DET_DISARMED);
endmodule

// >>> logic/facr_wait_gen.sv
`timescale 1ns/1ps
module facr_wait_gen #(
  parameter int CNT_W = 3
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       accessStart,
  input  wire logic       bufTick,
  input  wire logic [1:0] waitCode,
  output logic            local_ready_n
);
  facr_pkg::facr_wait_e state_reg;
  facr_pkg::facr_wait_e state_next;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cnt_next;

  // ----------------------------------------------------------------
  // code+1 tick edges give code to code+1 periods of wait
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      facr_pkg::WS_IDLE: begin
        if (accessStart && waitCode != 2'h0) begin
          state_next = facr_pkg::WS_WAIT;
          cnt_next   = CNT_W'(waitCode) + CNT_W'(1);
        end
      end
      facr_pkg::WS_WAIT: begin
        if (bufTick) begin
          cnt_next = cnt_reg - CNT_W'(1);
          if (cnt_reg == CNT_W'(1)) begin
            state_next = facr_pkg::WS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= facr_pkg::WS_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign local_ready_n = (state_reg == facr_pkg::WS_WAIT)
                      || (accessStart && waitCode != 2'h0);
endmodule

// >>> logic/facr_regs.sv
`timescale 1ns/1ps
module facr_regs #(
  parameter int WAIT_CNT_W = 3
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        hostSideReset,
  input  wire logic                        hostProgReset,
  input  wire logic                        hostCommand,
  input  wire logic [7:0]                  busAddr,
  input  wire logic                        busWrite,
  input  wire logic                        busRead,
  input  wire logic [7:0]                  busWdata,
  output logic      [7:0]                  busRdata,
  output logic                             local_ready_n,
  input  wire logic                        bufferCycleTick,
  input  wire logic                        pointerDirectionSelect,
  output logic                             bufferWritePointerInc,
  output logic                             bufferReadPointerInc,
  input  wire logic                        seqLoad,
  input  wire logic [7:0]                  seqNextIn,
  input  wire logic [7:0]                  seqCountIn,
  input  wire logic [7:0]                  seqControlIn,
  input  wire logic [7:0]                  seqDataIn,
  output logic      [7:0]                  seqNextAddr,
  output logic      [7:0]                  seqCount,
  output logic      [7:0]                  seqControl,
  output logic      [7:0]                  seqData,
  input  wire logic [facr_pkg::BRANCH_W-1:0] branchRegIn,
  output logic [facr_pkg::BRANCH_W-1:0]    branchAddr,
  input  wire logic                        eccErrorDetect,
  input  wire logic                        eccCalcStart,
  input  wire logic                        indexEdge,
  input  wire logic                        bufTransfer,
  input  wire logic                        read_gate_a,
  input  wire logic                        xtMode,
  input  wire logic                        hostStatusRead,
  input  wire logic                        lastSectorRead,
  input  wire logic                        fifoFull,
  input  wire logic                        hostDreq,
  output logic                             busyClear,
  output logic                             clockGateOff,
  output logic                             dmaEnableClear,
  output logic                             seqStopReq,
  output logic                             twoIndexArmed,
  output logic                             splitDataField,
  output logic                             nrzInputBlock,
  output logic                             rrcFilterBypass,
  output logic                             eccPresetZero
);
  logic [7:0] aux0_reg;
  logic [7:0] aux0_next;
  logic [7:0] aux1_reg;
  logic [7:0] aux1_next;
  logic [7:0] next_reg;
  logic [7:0] next_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       eccErr_reg;
  logic       eccErr_next;
  logic       pdLock_reg;
  logic       pdLock_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       hostRst;
  logic       access;

  facr_seq_if seqIf ();

  function automatic logic wrAt(input logic [7:0] a);
    wrAt = busWrite && busAddr == a;
  endfunction

  assign hostRst = hostSideReset || hostProgReset;
  assign access  = busWrite || busRead;

  // ----------------------------------------------------------------
  // current sequencer word
  // ----------------------------------------------------------------
  always_comb begin
    next_next  = next_reg;
    count_next = count_reg;
    ctrl_next  = ctrl_reg;
    data_next  = data_reg;
    if (seqLoad) begin
      next_next  = seqNextIn;
      count_next = seqCountIn;
      ctrl_next  = seqControlIn;
      data_next  = seqDataIn;
    end
    // firmware only writes while stopped, so it takes priority
    if (wrAt(facr_pkg::ADDR_SEQ_NEXT)) next_next = busWdata;
    if (wrAt(facr_pkg::ADDR_SEQ_COUNT)) count_next = busWdata;
    if (wrAt(facr_pkg::ADDR_SEQ_CTRL)) ctrl_next = busWdata;
    if (wrAt(facr_pkg::ADDR_SEQ_DATA)) data_next = busWdata;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      next_reg  <= facr_pkg::SEQ_RESET;
      count_reg <= facr_pkg::SEQ_RESET;
      ctrl_reg  <= facr_pkg::SEQ_RESET;
      data_reg  <= facr_pkg::SEQ_RESET;
    end else begin
      next_reg  <= next_next;
      count_reg <= count_next;
      ctrl_reg  <= ctrl_next;
      data_reg  <= data_next;
    end
  end

  assign seqNextAddr = next_reg;
  assign seqCount    = count_reg;
  assign seqControl  = ctrl_reg;
  assign seqData     = data_reg;

  // ----------------------------------------------------------------
  // auxiliary control registers and flags
  // ----------------------------------------------------------------
  always_comb begin
    aux0_next   = aux0_reg;
    aux1_next   = aux1_reg;
    pdLock_next = pdLock_reg;
    eccErr_next = eccErr_reg;
    if (wrAt(facr_pkg::ADDR_AUX_ZERO)) begin
      aux0_next = busWdata & facr_pkg::AUX0_WRITE_MASK;
      if (pdLock_reg) begin
        aux0_next[facr_pkg::A0_PWR_DOWN] =
          busWdata[facr_pkg::A0_PWR_DOWN]
          && aux0_reg[facr_pkg::A0_PWR_DOWN];
      end
    end
    if (wrAt(facr_pkg::ADDR_AUX_ONE)) begin
      aux1_next = busWdata & facr_pkg::AUX1_WRITE_MASK;
    end
    if (wrAt(facr_pkg::ADDR_LOCK_REL)) pdLock_next = 1'b0;
    if (hostCommand) begin
      pdLock_next = 1'b1;
      aux0_next[facr_pkg::A0_PWR_DOWN] = 1'b0;
    end
    if (hostRst) begin
      aux0_next[facr_pkg::A0_PWR_DOWN] = 1'b0;
      aux0_next[facr_pkg::A0_CLR_DMA]  = 1'b0;
    end
    if (wrAt(facr_pkg::ADDR_ECC_STAT) || eccCalcStart
        || (wrAt(facr_pkg::ADDR_FMT_CTRL)
            && busWdata[facr_pkg::FMT_RESET_BIT])) begin
      eccErr_next = 1'b0;
    end
    if (eccErrorDetect) eccErr_next = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aux0_reg   <= facr_pkg::AUX0_RESET;
      aux1_reg   <= facr_pkg::AUX1_RESET;
      pdLock_reg <= 1'b0;
      eccErr_reg <= 1'b0;
    end else begin
      aux0_reg   <= aux0_next;
      aux1_reg   <= aux1_next;
      pdLock_reg <= pdLock_next;
      eccErr_reg <= eccErr_next;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (busRead) begin
      unique case (busAddr)
        facr_pkg::ADDR_AUX_ZERO: begin
          rdata_next = aux0_reg;
          rdata_next[facr_pkg::A0_ECC_ERR] = eccErr_reg;
          rdata_next[facr_pkg::A0_TWO_IDX] = seqIf.detected;
        end
        facr_pkg::ADDR_SEQ_NEXT:  rdata_next = next_reg;
        facr_pkg::ADDR_SEQ_COUNT: rdata_next = count_reg;
        facr_pkg::ADDR_SEQ_CTRL:  rdata_next = ctrl_reg;
        facr_pkg::ADDR_SEQ_DATA:  rdata_next = data_reg;
        facr_pkg::ADDR_AUX_ONE:   rdata_next = aux1_reg;
        default:                  rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign busRdata = rdata_reg;

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic bufPortHit;
  assign bufPortHit = access && busAddr == facr_pkg::ADDR_BUF_PORT
                   && aux0_reg[facr_pkg::A0_AUTO_INC];
  assign bufferWritePointerInc = bufPortHit
                              && pointerDirectionSelect;
  assign bufferReadPointerInc  = bufPortHit
                              && !pointerDirectionSelect;
  assign clockGateOff   = aux0_reg[facr_pkg::A0_PWR_DOWN];
  assign dmaEnableClear = busWrite
                       && busAddr == facr_pkg::ADDR_AUX_ZERO
                       && aux0_reg[facr_pkg::A0_CLR_DMA]
                       && !busWdata[facr_pkg::A0_CLR_DMA];
  assign branchAddr = aux0_reg[facr_pkg::A0_DATA_BR]
                    ? data_reg[facr_pkg::BRANCH_W-1:0]
                    : branchRegIn;
  assign splitDataField = aux0_reg[facr_pkg::A0_SPLIT_EN]
                       && ctrl_reg[facr_pkg::CTL_SPLIT];
  assign nrzInputBlock = !aux0_reg[facr_pkg::A0_SPLIT_EN]
                      && ctrl_reg[facr_pkg::CTL_SPLIT]
                      && read_gate_a;
  assign busyClear = aux1_reg[facr_pkg::A1_BUSY_CLR]
                  && (xtMode ? hostStatusRead
                      : (lastSectorRead && fifoFull
                         && hostDreq));
  assign rrcFilterBypass = aux1_reg[facr_pkg::A1_FILT_DIS];
  assign eccPresetZero   = aux1_reg[facr_pkg::A1_ECC_PRESET];

  // ----------------------------------------------------------------
  // two-index detector and wait states
  // ----------------------------------------------------------------
  assign seqIf.wordCount   = count_reg;
  assign seqIf.wordControl = ctrl_reg;
  assign seqIf.execPulse   = seqLoad;
  assign seqIf.modeEn      = aux0_reg[facr_pkg::A0_TWO_IDX_EN];
  assign seqStopReq        = seqIf.detected;
  assign twoIndexArmed     = seqIf.armed;

  facr_two_index u_two_index (
    .clk         (clk),
    .reset       (reset),
    .seq         (seqIf),
    .indexEdge   (indexEdge),
    .bufTransfer (bufTransfer)
  );

  facr_wait_gen #(
    .CNT_W (WAIT_CNT_W)
  ) u_wait_gen (
    .clk           (clk),
    .reset         (reset),
    .accessStart   (access),
    .bufTick       (bufferCycleTick),
    .waitCode      (aux1_reg[facr_pkg::A1_WAIT_HI:facr_pkg::A1_WAIT_LO]),
    .local_ready_n (local_ready_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  aux0_reset_a: assert property (disable iff (1'b0)
    reset |=> aux0_reg == facr_pkg::AUX0_RESET)
    else $error("aux0 not reset");
  aux1_reset_a: assert property (disable iff (1'b0)
    reset |=> aux1_reg == facr_pkg::AUX1_RESET)
    else $error("aux1 not reset to wait code 11");
  ptr_inc_a: assert property (
    (bufferWritePointerInc || bufferReadPointerInc) |->
      access && busAddr == facr_pkg::ADDR_BUF_PORT
      && !(bufferWritePointerInc && bufferReadPointerInc))
    else $error("pointer advance without buffer port access");
  pd_host_cmd_a: assert property (
    hostCommand
      ##1 (!(busWrite && busAddr == facr_pkg::ADDR_LOCK_REL))[*2]
      |-> !clockGateOff)
    else $error("power-down set while locked");
  ecc_flag_a: assert property (
    eccErrorDetect |=> eccErr_reg)
    else $error("ecc error not flagged");
  stop_on_det_a: assert property (
    $rose(seqIf.detected) |-> seqStopReq && !seqIf.armed
      && $past(seqIf.armed))
    else $error("detection did not stop and disarm");
  det_clear_a: assert property (
    !seqIf.modeEn |=> !seqIf.detected)
    else $error("two-index flag kept with mode off");
  branch_sel_a: assert property (
    $rose(aux0_reg[facr_pkg::A0_DATA_BR]) |->
      branchAddr == data_reg[facr_pkg::BRANCH_W-1:0])
    else $error("branch source wrong");
  nrz_block_a: assert property (
    nrzInputBlock |-> read_gate_a && !splitDataField)
    else $error("nrz blocked outside read gate");
  dma_clr_a: assert property (
    dmaEnableClear |-> $past(aux0_next[facr_pkg::A0_CLR_DMA])
      ##1 !aux0_reg[facr_pkg::A0_CLR_DMA])
    else $error("dma clear without prior set");
  no_wait_a: assert property (
    (access && aux1_reg[7:6] == 2'h0) |-> !local_ready_n)
    else $error("wait inserted with code 00");

  det_seen_c: cover property ($rose(seqIf.detected));
  pd_entry_c: cover property ($rose(clockGateOff));
  wait_max_c: cover property (
    access && aux1_reg[7:6] == 2'h3 ##1 local_ready_n[*4]);
  busy_clr_c: cover property (busyClear && !xtMode);
endmodule

// >>> verification/facr_mcu_model.sv
`timescale 1ns/1ps
module facr_mcu_model (
  input  wire logic       clk,
  input  wire logic       local_ready_n,
  output logic      [7:0] busAddr,
  output logic            busWrite,
  output logic            busRead,
  output logic      [7:0] busWdata,
  output int              waitCycles,
  output int              stalls
);
  initial {busAddr, busWdata, busWrite, busRead} = 18'h00000;
  // one access, then hold off while ready is withheld
  task automatic access(input logic [7:0] a, input logic w,
                        input logic [7:0] d);
    {busAddr, busWdata, busWrite, busRead} = {a, d, w, !w};
    @(posedge clk);
    #1;
    {busAddr, busWdata, busWrite, busRead} = {~a, ~d, 2'h0};
    waitCycles = 0;
    do begin
      @(posedge clk);
      #1;
      waitCycles++;
    end while (local_ready_n !== 1'h0 && waitCycles < 64);
    if (waitCycles == 64) stalls++;
  endtask
endmodule

// >>> verification/formatter_aux_control_regs_test.sv
`timescale 1ns/1ps
module formatter_aux_control_regs_test;
  logic       clk, reset, bufferCycleTick, pointerDirectionSelect;
  logic       read_gate_a, xtMode, hostStatusRead, lastSectorRead;
  logic       fifoFull, hostDreq, busyClear, local_ready_n, busWrite;
  logic       busRead, bufferWritePointerInc, bufferReadPointerInc;
  logic       clockGateOff, dmaEnableClear, seqStopReq, twoIndexArmed;
  logic       splitDataField, nrzInputBlock, rrcFilterBypass, eccPresetZero;
  logic [7:0] busAddr, busWdata, busRdata, seqNextIn, seqCountIn, d, pv;
  logic [7:0] seqControlIn, seqDataIn, seqNextAddr, seqCount, seqControl;
  logic [7:0] seqData, expQ[$];
  logic [4:0] branchRegIn, branchAddr;
  logic [1:0] incExp;
  logic       dmaExp;
  wire        hostCommand, hostSideReset, hostProgReset, eccErrorDetect;
  wire        eccCalcStart, indexEdge, seqLoad, bufTransfer;
  int         errors, checked, ticks, k;
  // event strobes, command first
  assign {hostCommand, hostSideReset, hostProgReset, eccErrorDetect,
          eccCalcStart, indexEdge, seqLoad, bufTransfer} = pv;
  facr_regs #(.WAIT_CNT_W(3)) i_dut (.*);
  facr_mcu_model i_mcu (.clk, .local_ready_n, .busAddr, .busWrite, .busRead,
                        .busWdata, .waitCycles(), .stalls());
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    ticks++;
    bufferCycleTick = (ticks % 3 == 0);
  end
  always @(posedge clk) begin
    if ((busWrite | busRead) === 1'h1 && busAddr === 8'h70) begin
      chk({bufferWritePointerInc, bufferReadPointerInc}, incExp);
    end
    if (busWrite === 1'h1 && busAddr === 8'h48) begin
      chk(dmaEnableClear, dmaExp);
    end
    if (busRead === 1'h1) begin
      #2;
      chk(busRdata, expQ.pop_front());
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic pulse(input logic [7:0] m);
    pv = m;
    @(posedge clk);
    #1;
    pv = 8'h00;
    @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w) expQ.push_back(v);
    i_mcu.access(a, w, v);
    if (i_mcu.stalls != 0) summarize();
  endtask
  task automatic summarize();
    errors = errors + i_mcu.stalls;
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'h1;
    {pv, incExp, branchRegIn, dmaExp} = 16'h0000;
    {pointerDirectionSelect, read_gate_a, xtMode, hostStatusRead} = 4'h0;
    {lastSectorRead, fifoFull, hostDreq} = 3'h0;
    {seqNextIn, seqCountIn, seqControlIn, seqDataIn} = 32'h00000000;
    d = 8'($urandom(34499));
    repeat (4) @(posedge clk);
    #1;
    reset = 1'h0;
    acc(1'h0, 8'h48, 8'h00);
    acc(1'h0, 8'h4F, 8'hC0);
    for (k = 0; k < 4; k++) begin
      d = 8'($urandom);
      acc(1'h1, 8'(8'h49 + k), d);
      acc(1'h0, 8'(8'h49 + k), d);
    end
    acc(1'h0, 8'h4D, 8'h00);
    branchRegIn = 5'($urandom);
    acc(1'h1, 8'h48, 8'h20);
    chk(branchAddr, d[4:0]);
    acc(1'h1, 8'h48, 8'h00);
    chk(branchAddr, branchRegIn);
    for (k = 0; k < 4; k++) begin
      acc(1'h1, 8'h4F, 8'(k << 6));
      acc(1'h1, 8'h4C, d);
      chk(8'(i_mcu.waitCycles - 3 * k - 1) < 8'h03, 1'h1);
    end
    d = 8'($urandom) & 8'h3F | 8'h08;
    acc(1'h1, 8'h4F, d);
    acc(1'h0, 8'h4F, d & 8'hF8);
    chk(rrcFilterBypass, d[4]);
    chk(eccPresetZero, d[5]);
    {xtMode, hostStatusRead} = 2'h3;
    #1;
    chk(busyClear, 1'h1);
    @(posedge clk);
    #1;
    {xtMode, hostStatusRead, lastSectorRead, fifoFull, hostDreq} = 5'h07;
    #1;
    chk(busyClear, 1'h1);
    @(posedge clk);
    #1;
    acc(1'h1, 8'h48, 8'h02);
    chk(clockGateOff, 1'h1);
    pulse(8'h80);
    acc(1'h1, 8'h48, 8'h02);
    acc(1'h0, 8'h48, 8'h00);
    acc(1'h1, 8'h73, 8'h00);
    acc(1'h1, 8'h48, 8'h02);
    acc(1'h0, 8'h48, 8'h02);
    pulse(8'h40);
    acc(1'h0, 8'h48, 8'h00);
    acc(1'h1, 8'h48, 8'h10);
    acc(1'h0, 8'h48, 8'h10);
    pulse(8'h20);
    acc(1'h0, 8'h48, 8'h00);
    acc(1'h1, 8'h48, 8'h10);
    dmaExp = 1'h1;
    acc(1'h1, 8'h48, 8'h00);
    dmaExp = 1'h0;
    pulse(8'h10);
    acc(1'h0, 8'h48, 8'h04);
    acc(1'h1, 8'h79, 8'h00);
    acc(1'h0, 8'h48, 8'h00);
    pulse(8'h10);
    pulse(8'h08);
    acc(1'h0, 8'h48, 8'h00);
    acc(1'h1, 8'h48, 8'h01);
    {pointerDirectionSelect, incExp} = 3'h6;
    acc(1'h1, 8'h70, 8'h00);
    {pointerDirectionSelect, incExp} = 3'h1;
    acc(1'h1, 8'h70, 8'h00);
    {seqNextIn, seqCountIn, seqControlIn, seqDataIn, incExp} =
      {d, 16'h2000, d, 2'h0};
    acc(1'h1, 8'h48, 8'h40);
    acc(1'h1, 8'h70, 8'h00);
    pulse(8'h02);
    pulse(8'h02);
    chk(twoIndexArmed, 1'h1);
    pulse(8'h04);
    pulse(8'h04);
    chk(seqStopReq, 1'h1);
    chk(twoIndexArmed, 1'h0);
    acc(1'h0, 8'h48, 8'h48);
    chk(seqNextAddr, d);
    chk(seqCount, 8'h20);
    chk(seqControl, 8'h00);
    chk(seqData, d);
    acc(1'h1, 8'h48, 8'h00);
    acc(1'h0, 8'h48, 8'h00);
    acc(1'h1, 8'h48, 8'h40);
    pulse(8'h02);
    chk(twoIndexArmed, 1'h1);
    pulse(8'h01);
    chk(twoIndexArmed, 1'h0);
    read_gate_a = 1'h1;
    acc(1'h1, 8'h4B, 8'h08);
    chk(nrzInputBlock, 1'h1);
    acc(1'h1, 8'h48, 8'h80);
    chk(splitDataField, 1'h1);
    chk(nrzInputBlock, 1'h0);
    summarize();
  end
endmodule
